// ===== cbt_dram_model.sv
// device model for command bus training: set point swap, vref capture, ca echo
// assumes the controller drives cke, cs, ca, strobe and dq from its own pins
`default_nettype none
module cbt_dram_model #(
    parameter logic [6:0] VREF_ORIG = 7'h12,
    parameter logic [6:0] VREF_ALT = 7'h00
) (
    // controller pins
    input wire logic cke,
    input wire logic cs,
    input wire logic [5:0] ca,
    input wire logic dqs_t,
    input wire logic dqs_oe_n,
    input wire logic [6:0] dq,
    // device side
    output logic [5:0] ca_echo,
    output logic [6:0] vref_tmp,
    output logic fsp_alt
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ca_echo = 6'h15;
        vref_tmp = VREF_ORIG;
        fsp_alt = 1'b0;
    end
    // termination follows the set point flag; this die has no termination strap
    always @(negedge cke) begin
        fsp_alt = 1'b1;
        vref_tmp = VREF_ALT;
    end
    always @(posedge cke) begin
        fsp_alt = 1'b0;
        vref_tmp = VREF_ORIG;
        #2 ca_echo = ~ca_echo;
    end
    // each edge overwrites the last; applied at once, well inside the settle limit
    always @(dqs_t) if (!cke && !dqs_oe_n) vref_tmp = dq;
    // ca settles in the same step as cs, so it is read a little after the edge
    always @(posedge cs) if (!cke) begin
        #1;
        ca_echo <= #9 ca;
    end
endmodule
`default_nettype wire

// ===== cbt_host_ctrl.sv
// host controller that drives a low-power dram through command bus training
// assumes a classic wishbone master and the dram pins sampled on clk_sys
//
// The implementer's own choices: the Wishbone register port and the register offsets.
`default_nettype none
module cbt_host_ctrl (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // dram clock and command
    output logic ck_t,
    output logic ck_c,
    output logic cke,
    output logic cs,
    output logic [cbt_pkg::CA_W-1:0] ca,
    // strobe, driven only during training
    output logic dqs_t_o,
    output logic dqs_c_o,
    output logic dqs_oe_n,
    // vref data out and ca echo in
    output logic [cbt_pkg::VREF_W-1:0] dq_o,
    output logic dq_oe_n,
    input wire logic [cbt_pkg::CA_W-1:0] ca_echo_i
);
    import cbt_pkg::*;

    typedef struct packed {
        cbt_state_t state;
        logic [7:0] div_cnt;
        logic ck;
        logic ck_n;
        logic sel_train;
        logic cke;
        logic cs;
        logic [5:0] ca;
        logic dqs_t;
        logic dqs_c;
        logic dqs_oe_n;
        logic [6:0] dq;
        logic dq_oe_n;
        logic [2:0] beat;
        logic [4:0] pcnt;
        logic ack;
        logic [31:0] rdat;
        logic [7:0] div_norm;
        logic [7:0] div_train;
        logic [6:0] vref_new;
        logic [6:0] vref_cur;
        logic [3:0] npulse;
        logic rng_chg;
        logic [5:0] ca_pat;
        logic [23:0] ent_cmd;
        logic [23:0] exit_cmd;
        logic [5:0] echo;
        logic echo_valid;
    } regs_t;

    regs_t r;
    regs_t n;
    logic tmr_load;
    logic [19:0] tmr_val;
    logic tmr_done;
    logic wr;
    logic fall;
    logic [7:0] div;
    logic go_enter;
    logic go_exit;
    logic go_vref;
    logic go_ca;
    logic one_step;
    logic [4:0] np2;
    logic [23:0] cmd;
    logic [6:0] lvl_diff;

    cbt_wait_timer #(.W(20)) u_timer (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .load(tmr_load),
        .load_val(tmr_val),
        .expired(tmr_done)
    );

    always_comb begin
        n = r;
        tmr_load = 1'b0;
        tmr_val = 20'h00000;
        go_enter = 1'b0;
        go_exit = 1'b0;
        go_vref = 1'b0;
        go_ca = 1'b0;
        // ack one cycle after the strobe; write lands on the ack edge
        n.ack = wb_cyc_i & wb_stb_i & ~r.ack;
        wr = wb_cyc_i & wb_stb_i & wb_we_i & r.ack;
        div = r.sel_train ? r.div_train : r.div_norm;
        // ck divider: free running so the clock never stops during training
        fall = (r.div_cnt >= div) && r.ck;
        if (r.div_cnt >= div) begin
            n.div_cnt = 8'h00;
            n.ck = ~r.ck;
            n.ck_n = r.ck;
        end else begin
            n.div_cnt = r.div_cnt + 8'h01;
        end
        if (wr) begin
            if (wb_adr_i == REG_CTRL) begin
                go_enter = wb_sel_i[0] & wb_dat_i[CTRL_ENTER];
                go_exit = wb_sel_i[0] & wb_dat_i[CTRL_EXIT];
                go_vref = wb_sel_i[0] & wb_dat_i[CTRL_VREF];
                go_ca = wb_sel_i[0] & wb_dat_i[CTRL_CA];
            end else if (wb_adr_i == REG_CLKDIV) begin
                if (wb_sel_i[0]) n.div_norm = wb_dat_i[7:0];
                if (wb_sel_i[1]) n.div_train = wb_dat_i[15:8];
            end else if (wb_adr_i == REG_VREF) begin
                if (wb_sel_i[0]) n.vref_new = wb_dat_i[6:0];
                if (wb_sel_i[1]) n.npulse = wb_dat_i[11:8];
                if (wb_sel_i[2]) n.rng_chg = wb_dat_i[VREF_RCHG_BIT];
            end else if (wb_adr_i == REG_CAPAT) begin
                if (wb_sel_i[0]) n.ca_pat = wb_dat_i[5:0];
            end else if (wb_adr_i == REG_ENTCMD) begin
                for (int i = 0; i < 3; i++) begin
                    if (wb_sel_i[i]) n.ent_cmd[i*8 +: 8] = wb_dat_i[i*8 +: 8];
                end
            end else if (wb_adr_i == REG_EXITCMD) begin
                for (int i = 0; i < 3; i++) begin
                    if (wb_sel_i[i]) n.exit_cmd[i*8 +: 8] = wb_dat_i[i*8 +: 8];
                end
            end
        end
        if (n.ack) begin
            if (wb_adr_i == REG_CLKDIV) begin
                n.rdat = {16'h0000, r.div_train, r.div_norm};
            end else if (wb_adr_i == REG_VREF) begin
                n.rdat = {15'h0000, r.rng_chg, 4'h0, r.npulse, 1'b0, r.vref_new};
            end else if (wb_adr_i == REG_CAPAT) begin
                n.rdat = {26'h0000000, r.ca_pat};
            end else if (wb_adr_i == REG_ENTCMD) begin
                n.rdat = {8'h00, r.ent_cmd};
            end else if (wb_adr_i == REG_EXITCMD) begin
                n.rdat = {8'h00, r.exit_cmd};
            end else if (wb_adr_i == REG_STATUS) begin
                n.rdat = {9'h000, r.vref_cur, 1'b0, r.echo_valid, r.echo, r.state,
                          r.sel_train, ~r.cke, r.state == S_READY,
                          (r.state != S_IDLE) && (r.state != S_READY)};
            end else begin
                n.rdat = 32'h00000000;
            end
        end
        // a one-step change keeps the range and moves the level by one
        lvl_diff = {1'b0, r.vref_new[5:0]} - {1'b0, r.vref_cur[5:0]};
        one_step = (r.vref_new[VREF_RANGE_BIT] == r.vref_cur[VREF_RANGE_BIT]) &&
                   ((lvl_diff == 7'h01) || (lvl_diff == 7'h7f));
        np2 = (r.npulse < 4'(MIN_DQS_PULSES)) ? 5'(2 * MIN_DQS_PULSES) : {r.npulse, 1'b0};
        cmd = (r.state == S_EXITCMD) ? r.exit_cmd : r.ent_cmd;
        case (r.state)
            S_IDLE: begin
                if (go_enter) begin
                    n.state = S_ENTCMD;
                    n.beat = 3'h0;
                end
            end
            S_ENTCMD, S_EXITCMD: begin
                // each mode write part is two beats, cs high on the first only
                if (fall) begin
                    if (r.beat == 3'h4) begin
                        n.cs = 1'b0;
                        n.ca = 6'h00;
                        if (r.state == S_ENTCMD) begin
                            n.dqs_t = 1'b0;
                            n.dqs_c = 1'b1;
                            n.dqs_oe_n = 1'b0;
                            n.dq = r.vref_cur;
                            n.dq_oe_n = 1'b0;
                            tmr_load = 1'b1;
                            tmr_val = C_DQSCKE;
                            n.state = S_PARK;
                        end else begin
                            n.state = S_IDLE;
                        end
                    end else begin
                        n.cs = ~r.beat[0];
                        n.ca = cmd[r.beat[1:0]*6 +: 6];
                        n.beat = r.beat + 3'h1;
                    end
                end
            end
            S_PARK: begin
                if (tmr_done) begin
                    n.cke = 1'b0;
                    tmr_load = 1'b1;
                    tmr_val = wait_cycles(T_CKELCK_PS, N_CKELCK, r.div_norm);
                    n.state = S_CKEL;
                end
            end
            S_CKEL: begin
                // ck keeps toggling and cs stays low until the interval ends
                if (tmr_done) begin
                    n.sel_train = 1'b1;
                    tmr_load = 1'b1;
                    tmr_val = wait_cycles(T_CAENT_PS, 1, r.div_train);
                    n.state = S_CAENT;
                end
            end
            S_CAENT: begin
                if (tmr_done) n.state = S_READY;
            end
            S_READY: begin
                if (go_vref) begin
                    n.dq = r.vref_new;
                    n.pcnt = 5'h00;
                    n.state = S_VPULSE;
                end else if (go_ca) begin
                    n.echo_valid = 1'b0;
                    tmr_load = 1'b1;
                    tmr_val = wait_cycles(T_XP_PS, N_XP, div) +
                              20'(N_PRECS_EXTRA * ck_cycles(div));
                    n.state = S_CAPRE;
                end else if (go_exit) begin
                    n.sel_train = 1'b0;
                    tmr_load = 1'b1;
                    tmr_val = wait_cycles(T_CKCKEH_PS, N_CKCKEH, r.div_norm);
                    n.state = S_EXCLK;
                end
            end
            S_VPULSE: begin
                // data was set a cycle earlier and stays static through every pulse
                if (r.pcnt == np2) begin
                    tmr_load = 1'b1;
                    tmr_val = one_step ? wait_cycles(T_VREF_SHORT_PS, 1, div) :
                              wait_cycles(T_VREF_LONG_PS, 1, div);
                    n.state = S_VWAIT;
                end else begin
                    n.pcnt = r.pcnt + 5'h01;
                    n.dqs_t = ~r.dqs_t;
                    n.dqs_c = r.dqs_t;
                end
            end
            S_VWAIT: begin
                if (tmr_done) begin
                    n.vref_cur = r.dq;
                    n.state = S_READY;
                end
            end
            S_CAPRE: begin
                if (tmr_done && fall) begin
                    n.cs = 1'b1;
                    n.ca = r.ca_pat;
                    n.state = S_CABEAT;
                end
            end
            S_CABEAT: begin
                if (fall) begin
                    n.cs = 1'b0;
                    n.ca = 6'h00;
                    tmr_load = 1'b1;
                    tmr_val = wait_cycles(T_XP_PS, N_XP, div);
                    if (tmr_val < 20'(cacd_nck(div) * ck_cycles(div))) begin
                        tmr_val = 20'(cacd_nck(div) * ck_cycles(div));
                    end
                    n.state = S_CAPOST;
                end
            end
            S_CAPOST: begin
                if (tmr_done) begin
                    n.echo = ca_echo_i;
                    n.echo_valid = 1'b1;
                    n.state = S_READY;
                end
            end
            S_EXCLK: begin
                if (tmr_done) begin
                    n.cke = 1'b1;
                    n.dqs_oe_n = 1'b1;
                    n.dq_oe_n = 1'b1;
                    tmr_load = 1'b1;
                    tmr_val = wait_cycles(r.rng_chg ? T_XCBT_LONG_PS : T_XCBT_SHORT_PS,
                                          N_XCBT, r.div_norm);
                    if (tmr_val < wait_cycles(T_VREF_LONG_PS, 1, r.div_norm)) begin
                        tmr_val = wait_cycles(T_VREF_LONG_PS, 1, r.div_norm);
                    end
                    n.state = S_EXWAIT;
                end
            end
            S_EXWAIT: begin
                if (tmr_done) begin
                    n.beat = 3'h0;
                    n.state = S_EXITCMD;
                end
            end
            default: n.state = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
            r.state <= S_IDLE;
            r.ck_n <= 1'b1;
            r.cke <= 1'b1;
            r.dqs_oe_n <= 1'b1;
            r.dq_oe_n <= 1'b1;
            r.dqs_c <= 1'b1;
            r.div_norm <= RST_DIV_NORM;
            r.div_train <= RST_DIV_TRAIN;
            r.vref_new <= RST_VREF;
            r.vref_cur <= RST_VREF;
            r.npulse <= RST_PULSES;
        end else begin
            r <= n;
        end
    end

    assign wb_dat_o = r.rdat;
    assign wb_ack_o = r.ack;
    assign ck_t = r.ck;
    assign ck_c = r.ck_n;
    assign cke = r.cke;
    assign cs = r.cs;
    assign ca = r.ca;
    assign dqs_t_o = r.dqs_t;
    assign dqs_c_o = r.dqs_c;
    assign dqs_oe_n = r.dqs_oe_n;
    assign dq_o = r.dq;
    assign dq_oe_n = r.dq_oe_n;

    // helper counters: cycles since the last cke edge and cycles cs has been low
    logic [15:0] gap_q;
    logic [15:0] csl_q;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            gap_q <= 16'hffff;
            csl_q <= 16'h0000;
        end else begin
            gap_q <= (n.cke != r.cke) ? 16'h0000 :
                     ((gap_q == 16'hffff) ? gap_q : gap_q + 16'h0001);
            csl_q <= n.cs ? 16'h0000 : ((csl_q == 16'hffff) ? csl_q : csl_q + 16'h0001);
        end
    end

    a_ckel_freq_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $rose(r.sel_train) |-> !r.cke &&
            gap_q >= 16'(wait_cycles(T_CKELCK_PS, N_CKELCK, r.div_norm) - 20'h1))
        else $error("frequency changed too soon after cke low");
    a_ckel_cs_low: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (r.state == S_CKEL) |-> !r.cs && !r.cke)
        else $error("cs high during post cke low interval");
    a_vref_two_pulses: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (r.state == S_VPULSE) ##1 (r.state == S_VWAIT) |-> $past(r.pcnt) >= 5'(2 * MIN_DQS_PULSES))
        else $error("fewer than two strobe pulses for vref");
    a_park_strobe: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $fell(r.cke) |-> $past(!r.dqs_t && r.dqs_c && !r.dqs_oe_n))
        else $error("strobe not parked before cke low");
    a_caent_gap: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $rose(r.cs) && !r.cke |-> gap_q >= 16'((T_CAENT_PS + CLK_PS - 1) / CLK_PS))
        else $error("training command too soon after cke low");
    a_exit_cs_low: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $rose(r.cke) |-> !r.cs && !r.sel_train &&
            csl_q >= 16'(wait_cycles(T_CKCKEH_PS, N_CKCKEH, r.div_norm)))
        else $error("cs or clock not settled before cke high");
    a_cacd_space: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $rose(r.echo_valid) |-> csl_q >= 16'(cacd_nck(r.div_train) * ck_cycles(r.div_train)))
        else $error("echo sampled before read delay");
    a_exit_wait: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $rose(r.cs) && r.cke && r.state == S_EXITCMD |->
            gap_q >= 16'(wait_cycles(T_VREF_LONG_PS, N_XCBT, r.div_norm)))
        else $error("command too soon after training exit");
    a_wb_ack_pulse: assert property (@(posedge clk_sys) disable iff (!arst_n)
        r.ack |=> !r.ack)
        else $error("ack held longer than one cycle");
endmodule
`default_nettype wire

// ===== cbt_pkg.sv
// constants, types and timing helpers for the command bus training controller
// assumes a single 50 MHz system clock; all times are held in picoseconds
`default_nettype none
package cbt_pkg;
    localparam int unsigned CLK_PS = 20000;
    localparam int unsigned CA_W = 6;
    localparam int unsigned VREF_W = 7;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CLKDIV = 8'h04;
    localparam logic [7:0] REG_VREF = 8'h08;
    localparam logic [7:0] REG_CAPAT = 8'h0c;
    localparam logic [7:0] REG_ENTCMD = 8'h10;
    localparam logic [7:0] REG_EXITCMD = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    // control bit positions
    localparam int unsigned CTRL_ENTER = 0;
    localparam int unsigned CTRL_EXIT = 1;
    localparam int unsigned CTRL_VREF = 2;
    localparam int unsigned CTRL_CA = 3;
    // vref register fields
    localparam int unsigned VREF_RANGE_BIT = 6;
    localparam int unsigned VREF_RCHG_BIT = 16;
    // reset values
    localparam logic [7:0] RST_DIV_NORM = 8'h03;
    localparam logic [7:0] RST_DIV_TRAIN = 8'h00;
    localparam logic [6:0] RST_VREF = 7'h00;
    localparam logic [3:0] RST_PULSES = 4'h2;
    // timing figures
    localparam int unsigned T_CKELCK_PS = 5000;
    localparam int unsigned N_CKELCK = 5;
    localparam int unsigned T_DQSCKE_PS = 10000;
    localparam int unsigned T_CAENT_PS = 250000;
    localparam int unsigned T_VREF_LONG_PS = 250000;
    localparam int unsigned T_VREF_SHORT_PS = 80000;
    localparam int unsigned T_XP_PS = 7500;
    localparam int unsigned N_XP = 5;
    localparam int unsigned N_PRECS_EXTRA = 2;
    localparam int unsigned T_CKCKEH_PS = 1750;
    localparam int unsigned N_CKCKEH = 3;
    localparam int unsigned T_ADR_PS = 20000;
    localparam int unsigned T_XCBT_SHORT_PS = 200000;
    localparam int unsigned T_XCBT_LONG_PS = 250000;
    localparam int unsigned N_XCBT = 5;
    localparam int unsigned MIN_DQS_PULSES = 2;
    localparam logic [19:0] C_DQSCKE = 20'((T_DQSCKE_PS + CLK_PS - 1) / CLK_PS);

    typedef enum logic [3:0] {
        S_IDLE = 4'b0000, S_ENTCMD = 4'b0001, S_PARK = 4'b0010, S_CKEL = 4'b0011,
        S_CAENT = 4'b0100, S_READY = 4'b0101, S_VPULSE = 4'b0110, S_VWAIT = 4'b0111,
        S_CAPRE = 4'b1000, S_CABEAT = 4'b1001, S_CAPOST = 4'b1010, S_EXCLK = 4'b1011,
        S_EXWAIT = 4'b1100, S_EXITCMD = 4'b1101
    } cbt_state_t;

    // system cycles in one ck period for a divider setting
    function automatic logic [19:0] ck_cycles(input logic [7:0] div);
        ck_cycles = {11'h000, div, 1'b0} + 20'h00002;
    endfunction

    // larger of a time (rounded up) and a number of ck periods, in system cycles
    function automatic logic [19:0] wait_cycles(input int unsigned ps,
                                                input int unsigned nck,
                                                input logic [7:0] div);
        int unsigned a;
        int unsigned b;
        a = (ps + CLK_PS - 1) / CLK_PS;
        b = nck * {12'h000, ck_cycles(div)};
        if (b > a) a = b;
        if (a == 0) a = 1;
        wait_cycles = a[19:0];
    endfunction

    // ck periods covering the asynchronous read delay, rounded up
    function automatic int unsigned cacd_nck(input logic [7:0] div);
        int unsigned p;
        p = CLK_PS * {12'h000, ck_cycles(div)};
        cacd_nck = (T_ADR_PS + p - 1) / p;
    endfunction
endpackage
`default_nettype wire

// ===== cbt_wait_timer.sv
// down counter used for every timed wait of the training controller
// assumes load is a one-cycle request; expired is registered
`default_nettype none
module cbt_wait_timer #(
    parameter int unsigned W = 20
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // control
    input wire logic load,
    input wire logic [W-1:0] load_val,
    // status
    output logic expired
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic expired;
    } tmr_t;
    tmr_t r;
    tmr_t n;

    always_comb begin
        n = r;
        if (load) begin
            n.cnt = load_val;
        end else if (r.cnt != '0) begin
            n.cnt = r.cnt - 1'b1;
        end
        n.expired = (n.cnt == '0);
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            r <= '{cnt: '0, expired: 1'b1};
        end else begin
            r <= n;
        end
    end

    assign expired = r.expired;
endmodule
`default_nettype wire

// ===== lpddr_command_bus_training_bench.sv
// self-checking bench: wishbone tasks, training entry, vref, ca and exit
// assumes the device model closes the loop from ca to the echo input
`default_nettype none
module lpddr_command_bus_training_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import cbt_pkg::*;
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("FAIL %s exp %h got %h", nm, e, g); end end
    logic clk_sys, arst_n, req, we, ack, ck_t, ck_c, cke, cs, dqs_t, dqs_c, dqs_oe_n, dq_oe_n;
    logic fsp_alt, dqs_ok, cs_at_ckeh;
    logic [7:0] adr;
    logic [31:0] wdat, rdat;
    logic [5:0] ca, echo;
    logic [6:0] dq, vref_tmp;
    int err_count = 0, n_tests = 0, n_dqs = 0, n_ck = 0;
    realtime t_ckel = 0, t_ckeh = 0, t_csh = 0, t_cs = 0;
    cbt_host_ctrl cbt_host_ctrl_inst (.clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(req),
        .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .ck_t(ck_t), .ck_c(ck_c), .cke(cke), .cs(cs),
        .ca(ca), .dqs_t_o(dqs_t), .dqs_c_o(dqs_c), .dqs_oe_n(dqs_oe_n), .dq_o(dq),
        .dq_oe_n(dq_oe_n), .ca_echo_i(echo));
    cbt_dram_model cbt_dram_model_inst (.cke(cke), .cs(cs), .ca(ca), .dqs_t(dqs_t),
        .dqs_oe_n(dqs_oe_n), .dq(dq), .ca_echo(echo), .vref_tmp(vref_tmp), .fsp_alt(fsp_alt));
    // timestamps of pin events, judged later by the scenarios
    always @(negedge cke) begin
        t_ckel = $realtime;
        dqs_ok = !dqs_oe_n && !dqs_t && dqs_c;
    end
    always @(posedge cke) begin
        t_ckeh = $realtime;
        cs_at_ckeh = cs;
    end
    always @(posedge cs) if (!cke) t_csh = $realtime;
    always @(posedge cs) if (cke && t_cs < t_ckeh) t_cs = $realtime;
    always @(posedge dqs_t) if (!dqs_oe_n) n_dqs++;
    always @(posedge ck_t) n_ck++;
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge clk_sys);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        // no own limit: only the watchdog ends a hung wait
        do begin
            @(posedge clk_sys);
        end while (ack !== 1'b1);
        q = rdat;
        req <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    // polls one status bit; a slow answer is cut off after a bounded count
    task automatic poll(input int b, input logic v, output logic [31:0] s);
        int n;
        n = 0;
        do begin
            wb(1'b0, REG_STATUS, 32'h0, s);
            n++;
        end while (s[b] !== v && n < 100);
        `CHK("status bit", v, s[b])
    endtask
    task automatic t_reset;
        logic [31:0] q;
        `CHK("oe after reset", 2'b11, {dqs_oe_n, dq_oe_n})
        wb(1'b0, REG_CLKDIV, 32'h0, q);
        `CHK("clkdiv", 32'h00000003, q)
        wb(1'b0, 8'h1c, 32'h0, q);
        `CHK("unmapped", 32'h0, q)
        wr(REG_EXITCMD, 32'h00fedcba);
        wb(1'b0, REG_EXITCMD, 32'h0, q);
        `CHK("exit cmd", 32'h00fedcba, q)
        wr(REG_CTRL, 32'h4);
        wb(1'b0, REG_STATUS, 32'h0, q);
        `CHK("refused vref", 2'b00, q[1:0])
    endtask
    task automatic t_enter;
        logic [31:0] s;
        wr(REG_CTRL, 32'h1);
        n_ck = 0;
        poll(1, 1'b1, s);
        `CHK("ck running", 1'b1, n_ck > 5)
        `CHK("ck pair", 1'b1, ck_t ^ ck_c)
        `CHK("cke low", 1'b0, cke)
        `CHK("set point", 1'b1, fsp_alt)
        `CHK("strobe parked", 1'b1, dqs_ok)
    endtask
    task automatic t_vref(input logic [31:0] d, input logic [6:0] code, input int p);
        logic [31:0] s;
        n_dqs = 0;
        wr(REG_VREF, d);
        wr(REG_CTRL, 32'h4);
        poll(1, 1'b1, s);
        `CHK("vref", code, vref_tmp)
        `CHK("pulses", p, n_dqs)
        `CHK("cur vref", code, s[22:16])
    endtask
    task automatic t_ca(input logic [5:0] pat);
        logic [31:0] s;
        wr(REG_CAPAT, {26'h0, pat});
        wr(REG_CTRL, 32'h8);
        poll(1, 1'b1, s);
        `CHK("echo", {1'b1, pat}, s[14:8])
        `CHK("first cmd gap", 1'b1, (t_csh - t_ckel) >= 250.0)
    endtask
    task automatic t_exit;
        logic [31:0] s;
        wr(REG_CTRL, 32'h2);
        poll(2, 1'b0, s);
        poll(0, 1'b0, s);
        `CHK("cs before cke", 1'b0, cs_at_ckeh)
        `CHK("clock sel", 1'b0, s[3])
        `CHK("set point back", 1'b0, fsp_alt)
        `CHK("vref back", 7'h12, vref_tmp)
        `CHK("dq released", 1'b1, dq_oe_n)
        `CHK("exit gap", 1'b1, (t_cs - t_ckeh) >= 250.0)
    endtask
    task automatic stop_test;
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #200us;
        err_count++;
        stop_test();
    end
    initial begin
        {arst_n, req, we, adr, wdat} = '0;
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_reset();
        t_enter();
        t_vref(32'h00000301, 7'h01, 3);
        t_vref(32'h00010245, 7'h45, 2);
        t_ca(6'h2a);
        t_ca(6'h15);
        t_exit();
        stop_test();
    end
endmodule
`default_nettype wire
